//--- src/scm_readout.sv
// Serial configuration memory readout controller.
//
// Functional notes
// - Data three-state on load, open-drain programming.
// - Each selected clock rise advances bit, except after a full load readout; address on bit wrap.
// - Reset/OE: enable high, reset low default.
// - Reset level clears address and bit counters outside programming.
// - Load driver on only at enable with select low.
// - Reset/OE polarity is a stored setting.
// - Write-protect high blocks lowest block writes.
// - Aux write-protects only matter while programming.
// - Select low, enable high: count and drive.
// - Select high freezes counters, enters standby.
// - Programming mode ignores chip select.
// - Chain enable low at maximum address.
// - Chain enable stays low while selected, enabled.
// - Then tracks select until disabled, then high.
// - Float data when chain enable asserts.
// - Downstream device drives on low select.
// - Device select only enables during programming.
// - Ready held low through power-on reset.
// - Standby keeps data floating regardless.
// - Address cleared at power-up before readout.
`default_nettype none

module scm_readout
    import scm_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int WORD_W = WORD_W_DEF,
    parameter int BIT_W  = BIT_W_DEF
) (
    input  wire  logic              sys_clk_i,                // System clock.
    input  wire  logic              rst_b_i,                  // Synchronous reset, low.
    input  wire  logic              clk_en_i,                 // Freezes all state when low.
    input  wire  logic              fpga_config_clock_i,      // Configuration clock level.
    input  wire  logic              chip_select_n_i,          // Chip select, low active.
    input  wire  logic              reset_oe_i,               // Combined reset/output enable.
    input  wire  logic              program_mode_select_n_i,  // Low enters programming.
    input  wire  logic              write_protect_i,          // Lowest block protect.
    input  wire  logic              write_protect_aux_first_i,
    input  wire  logic              write_protect_aux_second_i,
    input  wire  logic              device_select_pin_i,      // Select while programming.
    input  wire  logic              prog_data_i,              // Data pin level in.
    input  wire  logic              pol_wr_i,                 // Store new polarity.
    input  wire  logic              pol_reset_low_i,          // 1: reset level is low.
    input  wire  logic              mem_wr_i,                 // Programming write request.
    input  wire  logic [WORD_W-1:0] mem_wdata_i,              // Word to program.
    output var   logic              data_o,                   // Data pin drive value.
    output var   logic              data_oe_n_o,              // Low while driving data.
    output var   logic              chain_enable_out_n_o,     // Cascade enable, low.
    output var   logic              ready_oe_n_o,             // Low: ready pulled low.
    output var   logic              standby_o,                // Low-power standby.
    output var   logic              prog_active_o,            // Programming selected.
    output var   logic              wr_blocked_o              // Last write refused.
);

    // ====================================================================
    // State and storage.
    localparam int DEPTH = 1 << ADDR_W;

    // All registered state of the block except the memory array.
    typedef struct packed {
        scm_mode_t          mode;       // Operating mode.
        logic [POR_W-1:0]   por_cnt;    // Power-on reset progress.
        logic [ADDR_W-1:0]  addr;       // Word address counter.
        logic [BIT_W-1:0]   bitc;       // Bit within word.
        logic               clk_q;      // Previous config clock level.
        logic               pol_low;    // Stored reset polarity.
        logic               done;       // Whole array read out.
        logic               latch_hi;   // Chain enable held high after disable.
        logic               data;
        logic               data_oe_n;
        logic               ceo_n;
        logic               ready_oe_n;
        logic               standby;
        logic               prog;
        logic               blocked;
    } scm_state_t;

    scm_state_t st;       // Current state.
    scm_state_t next_st;  // Next state.

    // Memory array; an array keeps contents outside the reset path.
    logic [WORD_W-1:0] mem [DEPTH];

    // ====================================================================
    // Helpers.

    // Decodes the polarity setting into reset and enable levels.
    function automatic logic is_reset(input logic pin, input logic pol_low);
        return pol_low ? !pin : pin;
    endfunction

    // Write protect check: lowest quarter of the array forms the lowest block.
    function automatic logic in_low_block(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1 -: 2] == 2'b00;
    endfunction

    logic rst_lvl;  // Reset/OE at its reset level.
    logic oe_lvl;   // Reset/OE at its enable level.
    logic rise;     // Rising edge of config clock.
    logic at_end;   // Last bit of last word.

    assign rst_lvl = is_reset(reset_oe_i, st.pol_low);
    assign oe_lvl  = !rst_lvl;
    assign rise    = fpga_config_clock_i && !st.clk_q;
    assign at_end  = (&st.addr) && (&st.bitc);

    // ====================================================================
    // Next-state logic.
    always_comb begin
        logic sel;    // Readout selected and enabled.
        logic adv;    // Counter advances this cycle.
        logic wp_hit; // Programming write refused.
        sel    = 1'b0;
        adv    = 1'b0;
        wp_hit = 1'b0;
        next_st = st;
        next_st.clk_q = fpga_config_clock_i;

        case (st.mode)
            SCM_POR: begin
                next_st.ready_oe_n = 1'b0;
                next_st.addr = '0;
                next_st.bitc = '0;
                next_st.data_oe_n = 1'b1;
                if (st.por_cnt == POR_W'(POR_CYCLES - 1)) begin
                    next_st.mode       = SCM_STANDBY;
                    next_st.ready_oe_n = 1'b1;
                end else begin
                    next_st.por_cnt = st.por_cnt + POR_W'(1);
                end
            end
            default: begin
                // Serial enable picks loading or programming.
                if (!program_mode_select_n_i) begin
                    next_st.mode = SCM_PROG;
                end else if (chip_select_n_i) begin
                    next_st.mode = SCM_STANDBY;
                end else begin
                    next_st.mode = SCM_LOAD;
                end
            end
        endcase

        if (st.mode != SCM_POR) begin
            if (pol_wr_i && !program_mode_select_n_i) begin
                next_st.pol_low = pol_reset_low_i;
            end

            if (program_mode_select_n_i) begin
                // Reset/OE acts only with serial enable high.
                sel = !chip_select_n_i && oe_lvl;
                adv = sel && rise && !st.done;
                next_st.standby = chip_select_n_i;
            end else begin
                // Chip select ignored; device select enables.
                sel = device_select_pin_i;
                adv = sel && rise;
                next_st.standby = 1'b0;
                // Aux protects act only while programming.
                wp_hit = (write_protect_i && in_low_block(st.addr))
                       || (write_protect_aux_first_i && st.addr[ADDR_W-1])
                       || (write_protect_aux_second_i && (&st.addr[ADDR_W-1 -: 2]));
                if (sel && mem_wr_i) begin
                    next_st.blocked = wp_hit;
                end
            end
            next_st.prog = !program_mode_select_n_i && device_select_pin_i;

            // Clock pulse advances bit then address counter.
            if (adv) begin
                next_st.bitc = st.bitc + BIT_W'(1);
                if (&st.bitc) begin
                    next_st.addr = st.addr + ADDR_W'(1);
                end
                if (at_end && program_mode_select_n_i) begin
                    next_st.done = 1'b1;
                end
            end

            if (rst_lvl && program_mode_select_n_i) begin
                next_st.addr = '0;
                next_st.bitc = '0;
                next_st.done = 1'b0;
            end

            // Chain enable low after the final bit.
            // Stays low while selected and enabled.
            // Then follows select; high after disable.
            if (next_st.done) begin
                if (rst_lvl) begin
                    next_st.latch_hi = 1'b1;
                end
                next_st.ceo_n = st.latch_hi ? 1'b1 : chip_select_n_i;
            end else begin
                next_st.ceo_n    = 1'b1;
                next_st.latch_hi = 1'b0;
            end

            // Present bit at the current counter.
            next_st.data = mem[next_st.addr][next_st.bitc];
            // Three-state when loading, open drain when programming.
            if (program_mode_select_n_i) begin
                // Drive only selected, enabled, not done.
                next_st.data_oe_n = !(oe_lvl && !chip_select_n_i && !next_st.done);
            end else begin
                next_st.data      = 1'b0;
                next_st.data_oe_n = !(sel && !prog_data_i);
            end
        end
    end

    // ====================================================================
    // State register.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            st            <= '0;
            st.mode       <= SCM_POR;
            st.pol_low    <= POL_RESET_LOW;
            st.data_oe_n  <= 1'b1;
            st.ceo_n      <= 1'b1;
            st.ready_oe_n <= 1'b0;
            st.standby    <= 1'b1;
        end else if (clk_en_i) begin
            st <= next_st;
        end
    end

    // Programming writes land a whole word; refused writes leave memory alone.
    always_ff @(posedge sys_clk_i) begin
        if (clk_en_i && st.mode == SCM_PROG && device_select_pin_i && mem_wr_i
            && !next_st.blocked) begin
            mem[st.addr] <= mem_wdata_i;
        end
    end

    assign data_o               = st.data;
    assign data_oe_n_o          = st.data_oe_n;
    assign chain_enable_out_n_o = st.ceo_n;
    assign ready_oe_n_o         = st.ready_oe_n;
    assign standby_o            = st.standby;
    assign prog_active_o        = st.prog;
    assign wr_blocked_o         = st.blocked;

    // ====================================================================
    // Checks.
    sequence s_disabled;
        rst_lvl && program_mode_select_n_i;
    endsequence

    // Enabled cycle outside power-on; the first five checks below start from one.
    sequence s_live;
        clk_en_i && st.mode != SCM_POR;
    endsequence

    // Loading with the whole array already read out and the pin still enabled.
    sequence s_done_selected;
        st.done && !st.latch_hi && !chip_select_n_i && oe_lvl && program_mode_select_n_i;
    endsequence

    // Programming mode selected by the serial enable pin.
    sequence s_programming;
        !program_mode_select_n_i;
    endsequence

    a_counter_reset_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_live and s_disabled |=> st.addr == '0 && st.bitc == '0)
        else $error("counters not cleared at reset level");
    // The chain enable must not bounce while the next device is being read.
    a_chain_hold_low: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_live and s_done_selected |=> !chain_enable_out_n_o)
        else $error("chain enable released while selected");
    // Chip select has no say in programming mode, so standby never follows it.
    a_prog_no_standby: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_live and s_programming |=> !standby_o)
        else $error("standby entered while programming");
    // Without device select the programming side stays idle.
    a_prog_needs_dsel: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (s_live and s_programming) ##0 !device_select_pin_i |=> !prog_active_o)
        else $error("programming active without device select");
    // The pin is open drain while programming: it may only pull low.
    a_prog_open_drain: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_live and s_programming |=> !data_o)
        else $error("data driven high while programming");
    // Protect inputs are ignored while loading, so the refusal flag holds.
    a_load_no_refuse: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        clk_en_i && program_mode_select_n_i |=> $stable(wr_blocked_o))
        else $error("write refusal changed while loading");
    a_standby_float: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        clk_en_i && st.mode != SCM_POR && chip_select_n_i && program_mode_select_n_i
        |=> data_oe_n_o)
        else $error("data driven in standby");
    a_freeze_select: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        clk_en_i && st.mode != SCM_POR && chip_select_n_i && program_mode_select_n_i
        && !rst_lvl |=> $stable(st.addr) && $stable(st.bitc))
        else $error("counter moved while deselected");
    a_ready_low_por: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        st.mode == SCM_POR |-> !ready_oe_n_o)
        else $error("ready released during power-on");
    a_end_float: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !chain_enable_out_n_o && program_mode_select_n_i |-> data_oe_n_o)
        else $error("data driven with chain enable low");
    a_ceo_needs_done: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $fell(chain_enable_out_n_o) |-> $past(st.done) || st.done)
        else $error("chain enable low before end");
    a_advance_edge: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        clk_en_i && st.mode == SCM_LOAD && !chip_select_n_i && oe_lvl && rise && !st.done
        && program_mode_select_n_i |=> st.bitc == $past(st.bitc) + BIT_W'(1))
        else $error("counter did not advance on rising edge");
    a_oe_needs_sel: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !data_oe_n_o && $past(program_mode_select_n_i) |-> $past(!chip_select_n_i && oe_lvl))
        else $error("driver enabled without select and enable");

endmodule

`default_nettype wire

//--- src/scm_pkg.sv
// Constants and types shared by the serial configuration memory readout block.
package scm_pkg;
    // ====================================================================
    // Array geometry defaults.
    localparam int ADDR_W_DEF  = 12;   // Word address width.
    localparam int WORD_W_DEF  = 8;    // Bits per stored word.
    localparam int BIT_W_DEF   = 3;    // Bit counter width.
    // Number of system clocks the power-on reset cycle lasts.
    localparam int POR_CYCLES  = 16;
    localparam int POR_W       = 5;
    // Reset values.
    localparam logic POL_RESET_LOW = 1'b1;  // Default: reset active low.
    // Operating modes of the block.
    typedef enum logic [1:0] {
        SCM_POR,
        SCM_STANDBY,
        SCM_LOAD,
        SCM_PROG
    } scm_mode_t;
endpackage

//--- bench/scm_fpga_model.sv
// Behavioural master FPGA that clocks the memory and takes its data bits.
`default_nettype none
module scm_fpga_model (
    input  wire logic sys_clk_i,    // System clock.
    input  wire logic data_i,       // Data pin drive value of the memory.
    input  wire logic data_oe_n_i,  // Low while the memory drives the pin.
    output var  logic cfg_clk_o     // Configuration clock to the memory.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_bit = 1'b0;  // Last driven level, kept to model a floating pin.
    // The clock stands low outside frames.
    initial cfg_clk_o = 1'b0;
    // ====================================================================
    // Bit transfer
    // Take the bit on the pin, then give one clock pulse.
    // A floating pin shows the inverse of the last level, so a stale bit never matches.
    // clock and data
    task automatic take_bit(input int hold, output logic b);
        b = data_oe_n_i ? ~last_bit : data_i;
        if (!data_oe_n_i) begin
            last_bit = data_i;
        end
        @(posedge sys_clk_i) cfg_clk_o <= 1'b1;
        repeat (hold) @(posedge sys_clk_i);
        cfg_clk_o <= 1'b0;
        repeat (hold) @(posedge sys_clk_i);
        #1;
    endtask
endmodule
`default_nettype wire

//--- bench/test_serial_config_memory_readout.sv
// Self-checking testbench of the serial configuration memory readout block.
`default_nettype none
module test_serial_config_memory_readout;
    timeunit 1ns;
    timeprecision 1ps;
    import scm_pkg::*;
    logic sys_clk = 1'b0;  // 100 MHz system clock.
    logic rst_b = 1'b0;    // Synchronous reset, low.
    logic cs_n = 1'b1, roe = 1'b1, pms_n = 1'b1, dsel = 1'b0;
    logic wp = 1'b0, wa1 = 1'b0, wa2 = 1'b0, pol_wr = 1'b0, pol_low = 1'b1;
    logic mem_wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic cfg_clk, data, oe_n, ceo_n, rdy_n, stby, pact, wblk, b;
    logic [7:0] img [4] = '{8'hA5, 8'h3C, 8'h96, 8'h0F};  // Words stored.
    int error_cnt = 0;
    int n_compared = 0;
    // Open-drain data pin with pull-up, read back by the device.
    wire prog_pin = oe_n ? 1'b1 : data;
    always #5 sys_clk = ~sys_clk;
    // A four-word array keeps a full readout short.
    scm_readout #(.ADDR_W(2), .WORD_W(8), .BIT_W(3)) uut (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .clk_en_i(1'b1),
        .fpga_config_clock_i(cfg_clk), .chip_select_n_i(cs_n), .reset_oe_i(roe),
        .program_mode_select_n_i(pms_n), .write_protect_i(wp),
        .write_protect_aux_first_i(wa1), .write_protect_aux_second_i(wa2),
        .device_select_pin_i(dsel), .prog_data_i(prog_pin), .pol_wr_i(pol_wr),
        .pol_reset_low_i(pol_low), .mem_wr_i(mem_wr), .mem_wdata_i(wdata),
        .data_o(data), .data_oe_n_o(oe_n), .chain_enable_out_n_o(ceo_n),
        .ready_oe_n_o(rdy_n), .standby_o(stby), .prog_active_o(pact),
        .wr_blocked_o(wblk));
    scm_fpga_model fpga (.sys_clk_i(sys_clk), .data_i(data), .data_oe_n_i(oe_n),
        .cfg_clk_o(cfg_clk));
    // ====================================================================
    // Shared helpers
    task automatic check(input string what, input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask
    // Let n edges pass and step past them so outputs are settled.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // One programming write with the given protect levels {wp, aux1, aux2}.
    task automatic wr(input logic [7:0] d, input logic [2:0] prot, input logic blk);
        @(posedge sys_clk) {wp, wa1, wa2} <= prot;
        wdata <= d;
        mem_wr <= 1'b1;
        @(posedge sys_clk) mem_wr <= 1'b0;
        tick(2);
        check("write refused", wblk, blk);
        if (!blk) begin
            repeat (8) fpga.take_bit(1, b);
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ====================================================================
    // Scenarios
    // Ready stays low through the power-on cycle, then is released.
    task automatic t_power_up;
        int i;
        tick(1);
        check("ready low", rdy_n, 1'b0);  // power-on ready
        for (i = 0; i < POR_CYCLES + 4 && !rdy_n; i++) tick(1);
        check("ready released", rdy_n, 1'b1);  // power-on ready
        check("idle chain", ceo_n, 1'b1);  // cleared at power-up
    endtask
    // Programming with chip select high, device select and protect zones.
    task automatic t_program;
        @(posedge sys_clk) pms_n <= 1'b0;  // enter programming
        tick(2);
        check("prog unselected", pact, 1'b0);  // device select
        @(posedge sys_clk) dsel <= 1'b1;
        tick(2);
        check("prog selected", pact, 1'b1);  // select ignored
        wr(img[0], 3'b100, 1'b1);  // lowest block protected
        wr(img[0], 3'b000, 1'b0);  // whole memory writable
        wr(img[1], 3'b000, 1'b0);  // address advances
        wr(img[2], 3'b010, 1'b1);  // upper half protected
        wr(img[2], 3'b000, 1'b0);  // unprotected
        wr(img[3], 3'b001, 1'b1);  // top quarter protected
        wr(img[3], 3'b000, 1'b0);  // unprotected
    endtask
    // Full readout, stalled by chip select in mid-stream, with protects high.
    task automatic t_readout(input int hold, input int pause);
        @(posedge sys_clk) pms_n <= 1'b1;  // loading
        {roe, cs_n, wp, wa1, wa2} <= 5'b00111;
        tick(2);
        check("float in reset", oe_n, 1'b1);  // reset level
        @(posedge sys_clk) roe <= 1'b1;
        tick(2);
        check("driving", oe_n, 1'b0);  // select and enable
        check("active", stby, 1'b0);  // not standby
        for (int k = 0; k < 32; k++) begin
            if (k == pause) begin
                @(posedge sys_clk) cs_n <= 1'b1;
                tick(2);
                check("standby", stby, 1'b1);  // standby
                check("float standby", oe_n, 1'b1);  // floating
                repeat (2) fpga.take_bit(hold, b);
                @(posedge sys_clk) cs_n <= 1'b0;
                tick(2);
            end
            fpga.take_bit(hold, b);
            check("data bit", b, img[k / 8][k % 8]);  // bit order
        end
        tick(1);
        check("chain low", ceo_n, 1'b0);  // chain at end
        check("float at end", oe_n, 1'b1);  // released
    endtask
    // Chain enable holds, follows chip select, then stays high after disable.
    task automatic t_chain;
        tick(3);
        check("chain held", ceo_n, 1'b0);  // chain held
        @(posedge sys_clk) cs_n <= 1'b1;
        tick(2);
        check("chain follows hi", ceo_n, 1'b1);  // follows select
        @(posedge sys_clk) cs_n <= 1'b0;
        tick(2);
        check("chain follows lo", ceo_n, 1'b0);  // follows select
        @(posedge sys_clk) roe <= 1'b0;
        tick(2);
        check("chain after reset", ceo_n, 1'b1);  // disabled
        @(posedge sys_clk) roe <= 1'b1;
        tick(2);
        check("chain stays high", ceo_n, 1'b1);  // until reread
        check("first bit again", data, img[0][0]);  // counters cleared
    endtask
    // Stored polarity inverted: low now enables, high resets.
    task automatic t_polarity;
        @(posedge sys_clk) roe <= 1'b0;
        tick(2);
        check("chain cleared", ceo_n, 1'b1);  // reset clears end
        @(posedge sys_clk) pms_n <= 1'b0;
        pol_low <= 1'b0;
        pol_wr <= 1'b1;
        @(posedge sys_clk) pol_wr <= 1'b0;
        pms_n <= 1'b1;
        roe <= 1'b0;
        tick(2);
        check("inverted enable", oe_n, 1'b0);  // stored polarity
        @(posedge sys_clk) roe <= 1'b1;
        tick(2);
        check("inverted reset", oe_n, 1'b1);  // stored polarity
    endtask
    // ====================================================================
    // Main sequence and watchdog
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_power_up();
        t_program();
        t_readout(1, 3);
        t_chain();
        t_readout(3, 20);
        t_polarity();
        end_of_test();
    end
    // The run needs about 550 cycles; cut it off well beyond that.
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule
`default_nettype wire
